// [dar_pkg.sv]
package dar_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte addresses
  localparam logic [3:0] ADDR_SAMPLE0     = 4'h0;
  localparam logic [3:0] ADDR_SAMPLE0_MID = 4'h1;
  localparam logic [3:0] ADDR_SAMPLE0_LSB = 4'h2;
  localparam logic [3:0] ADDR_SAMPLE1     = 4'h3;
  localparam logic [3:0] ADDR_SAMPLE1_MID = 4'h4;
  localparam logic [3:0] ADDR_SAMPLE1_LSB = 4'h5;
  localparam logic [3:0] ADDR_SNAPSHOT    = 4'h6;
  localparam logic [3:0] ADDR_SKEW        = 4'h7;
  localparam logic [3:0] ADDR_GAIN        = 4'h8;
  localparam logic [3:0] ADDR_LINK        = 4'h9;
  localparam logic [3:0] ADDR_SETUP1      = 4'hA;
  localparam logic [3:0] ADDR_SETUP2      = 4'hB;
  localparam logic [3:0] GROUP_SPAN       = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_SNAPSHOT = 8'h33;
  localparam logic [7:0] RST_SKEW     = 8'h00;
  localparam logic [7:0] RST_GAIN     = 8'h00;
  localparam logic [7:0] RST_LINK     = 8'hA3;
  localparam logic [7:0] RST_SETUP1   = 8'h10;
  localparam logic [7:0] RST_SETUP2   = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int LINK_LOOP_HI   = 7;
  localparam int LINK_LOOP_LO   = 6;
  localparam int LINK_SETTLE    = 5;
  localparam int LINK_HIZN      = 4;
  localparam int LINK_SEL_HI    = 3;
  localparam int LINK_SEL_LO    = 2;
  localparam int LINK_CTL_LO    = 2;
  localparam int SETUP1_OSR_HI  = 5;
  localparam int SETUP1_OSR_LO  = 4;
  localparam int SETUP2_RST_CH1 = 7;
  localparam int SETUP2_RST_CH0 = 6;
  localparam int SETUP2_SHD_CH1 = 5;
  localparam int SETUP2_SHD_CH0 = 4;
  localparam int GAIN_UPPER_HI  = 7;
  localparam int GAIN_UPPER_LO  = 5;
  localparam int GAIN_BIAS_CH1  = 4;
  localparam int GAIN_BIAS_CH0  = 3;
  localparam int GAIN_LOWER_HI  = 2;
  localparam int GAIN_LOWER_LO  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Codes and counts
  localparam logic [1:0] LOOP_SAME   = 2'b00;
  localparam logic [1:0] LOOP_GROUP  = 2'b01;
  localparam logic [1:0] LOOP_TYPE   = 2'b10;
  localparam logic [1:0] LOOP_MAP    = 2'b11;
  localparam logic [1:0] SEL_LINKED  = 2'b00;
  localparam logic [1:0] SEL_CH0     = 2'b01;
  localparam logic [1:0] SEL_CH1     = 2'b10;
  localparam logic [1:0] SEL_BOTH    = 2'b11;
  localparam logic [1:0] SETTLE_WORDS   = 2'h3;
  localparam logic [1:0] CORRUPT_PULSES = 2'h3;
  localparam logic [2:0] GAIN_CODE_MAX  = 3'h5;
  localparam logic [7:0] OSR_MASK_MAX   = 8'hFF;

endpackage : dar_pkg

// [dar_chan_if.sv]
`timescale 1ns/1ps
interface dar_chan_if;
  logic        awake;
  logic        settle_en;
  logic        conv_evt;
  logic        capture;
  logic        read_begin;
  logic        read_end;
  logic [23:0] sample_raw;
  logic        done;
  logic [23:0] view;

  modport top  (output awake, settle_en, conv_evt, capture, read_begin, read_end, sample_raw,
                input done, view);
  modport chan (input awake, settle_en, conv_evt, capture, read_begin, read_end, sample_raw,
                output done, view);
endinterface : dar_chan_if

// [dar_chan.sv]
`timescale 1ns/1ps
module dar_chan (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Channel link to the register map
  dar_chan_if.chan ch
);

  logic [23:0] sync1_r;
  logic [23:0] sync2_r;
  logic [23:0] fresh_r;
  logic [23:0] hold_r;
  logic        frozen_r;
  logic [1:0]  settle_r;

  ////////////////////////////////////////////////////////////////////////////
  // Converter word enters from the analog side
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 24'h000000;
      sync2_r <= 24'h000000;
    end else begin
      sync1_r <= ch.sample_raw;
      sync2_r <= sync1_r;
    end
  end

  // Sleeping channel never completes a conversion
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_r <= 2'h0;
    end else if (!ch.awake) begin
      settle_r <= 2'h0;
    end else if (ch.conv_evt && settle_r != dar_pkg::SETTLE_WORDS) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  assign ch.done = ch.awake && ch.conv_evt &&
                   (!ch.settle_en || settle_r == dar_pkg::SETTLE_WORDS);

  ////////////////////////////////////////////////////////////////////////////
  // Two latches: fresh result, and the copy frozen for a read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fresh_r <= 24'h000000;
    end else if (ch.capture) begin
      fresh_r <= sync2_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r   <= 24'h000000;
      frozen_r <= 1'b0;
    end else begin
      if (ch.read_begin && !frozen_r) begin
        hold_r <= fresh_r;
      end
      if (ch.read_end) begin
        frozen_r <= 1'b0;
      end else if (ch.read_begin) begin
        frozen_r <= 1'b1;
      end
    end
  end

  // A capture during a read lands in fresh_r only
  assign ch.view = frozen_r ? hold_r : fresh_r;

endmodule : dar_chan

// [dar_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Linked select: no ready pulse while either channel sleeps in reset or shutdown.
// - Linked select: one pulse only when both channels hold a fresh result.
// - Both-pulses select: an awake channel still pulses while the other sleeps.
// - Every location is one byte and addressable alone.
// - Channel 0 result at 0x00, channel 1 at 0x03, top byte first.
// - Snapshot 0x06, skew 0x07, gain 0x08, link 0x09, setups 0x0A and 0x0B.
// - Read counter wraps per group, per type, over whole map, or stays.
// - Result bytes are read-only and hold the latest conversion.
// - Reading freezes a result; a new conversion is kept apart meanwhile.
// - All three result bytes refresh together once per word period.
// - Snapshot holds four comparator bits per channel, resets to 0011 each.
// - Snapshot refreshes on every modulator clock cycle.
// - Writing the snapshot spoils results for the next three ready pulses.
// - Skew code is signed; positive makes channel 0 lag channel 1.
// - Delay equals the skew code times one modulator clock period.
// - Sign bit of skew moves with oversample ratio: bit 7 down to 4.
// - Amplifier codes give gains 1 to 32; codes 110 and 111 give 1.
// - Gain bits 4 and 3 double bias current of channel 1 and 0.
// - Select 01 ch0, 10 ch1, 11 both, 00 lagging channel, latched together.
// - Ready pulse is low one modulator period, once per word period; under select 11 with both awake, twice at skew beyond +-1, once for two periods at +-1.
module dar_top (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Analog core
  input  wire logic        mod_clk_in,
  input  wire logic [3:0]  comp_upper_in,
  input  wire logic [3:0]  comp_lower_in,
  input  wire logic [23:0] sample_ch0_in,
  input  wire logic [23:0] sample_ch1_in,
  // Host byte access
  input  wire logic        acc_start_in,
  input  wire logic [3:0]  acc_addr_in,
  input  wire logic        acc_rd_in,
  input  wire logic        acc_wr_in,
  input  wire logic [7:0]  acc_wdata_in,
  input  wire logic        acc_end_in,
  output logic      [7:0]  acc_rdata_out,
  output logic             acc_rvalid_out,
  // Ready pin
  output logic             sample_ready_n_out,
  output logic             sample_ready_oe_out,
  // Analog settings
  output logic      [5:0]  amp_gain_upper_out,
  output logic      [5:0]  amp_gain_lower_out,
  output logic      [1:0]  bias_double_out,
  output logic signed [8:0] channel_delay_out,
  output logic      [1:0]  chan_awake_out,
  output logic      [1:0]  results_spoiled_out
);

  dar_chan_if c0 ();
  dar_chan_if c1 ();

  logic        mclk_s1_r;
  logic        mclk_s2_r;
  logic        mclk_s3_r;
  logic [3:0]  comp_up_s1_r;
  logic [3:0]  comp_up_s2_r;
  logic [3:0]  comp_lo_s1_r;
  logic [3:0]  comp_lo_s2_r;
  logic [7:0]  snapshot_r;
  logic [7:0]  skew_r;
  logic [7:0]  gain_r;
  logic [7:2]  link_ctl_r;
  logic [1:0]  status_r;
  logic [7:0]  setup1_r;
  logic [7:0]  setup2_r;
  logic [3:0]  addr_r;
  logic [7:0]  word_cnt_r;
  logic [1:0]  pend_r;
  logic [1:0]  spoil_r;
  logic        ready_n_nxt;

  logic        tick;
  logic        wr_hit;
  logic        rd_hit;
  logic [1:0]  osr_code;
  logic [7:0]  osr_mask;
  logic signed [8:0] skew_ext;
  logic [1:0]  sel;
  logic        linked;
  logic [1:0]  done;
  logic        both_ready;
  logic        ready_evt;
  logic [1:0]  ev_chan;
  logic [7:0]  rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Inputs from outside the clock domain
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mclk_s1_r    <= 1'b0;
      mclk_s2_r    <= 1'b0;
      mclk_s3_r    <= 1'b0;
      comp_up_s1_r <= 4'h0;
      comp_up_s2_r <= 4'h0;
      comp_lo_s1_r <= 4'h0;
      comp_lo_s2_r <= 4'h0;
    end else begin
      mclk_s1_r    <= mod_clk_in;
      mclk_s2_r    <= mclk_s1_r;
      mclk_s3_r    <= mclk_s2_r;
      comp_up_s1_r <= comp_upper_in;
      comp_up_s2_r <= comp_up_s1_r;
      comp_lo_s1_r <= comp_lower_in;
      comp_lo_s2_r <= comp_lo_s1_r;
    end
  end

  // Rising modulator edge, one cycle enable
  assign tick = mclk_s2_r & ~mclk_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address counter
  function automatic logic [3:0] next_addr(input logic [3:0] a, input logic [1:0] loop);
    logic [3:0] inc;
    inc = a + 4'h1;
    case (loop)
      dar_pkg::LOOP_GROUP: begin
        if (a == dar_pkg::ADDR_SAMPLE0_LSB || a == dar_pkg::ADDR_SAMPLE1_LSB ||
            a == dar_pkg::ADDR_GAIN || a == dar_pkg::ADDR_SETUP2) begin
          next_addr = a - dar_pkg::GROUP_SPAN;
        end else begin
          next_addr = inc;
        end
      end
      dar_pkg::LOOP_TYPE: begin
        if (a == dar_pkg::ADDR_SAMPLE1_LSB) begin
          next_addr = dar_pkg::ADDR_SAMPLE0;
        end else if (a == dar_pkg::ADDR_SETUP2) begin
          next_addr = dar_pkg::ADDR_SNAPSHOT;
        end else begin
          next_addr = inc;
        end
      end
      dar_pkg::LOOP_MAP: begin
        next_addr = (a >= dar_pkg::ADDR_SETUP2) ? dar_pkg::ADDR_SAMPLE0 : inc;
      end
      default: begin
        next_addr = a;
      end
    endcase
  endfunction : next_addr

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r <= dar_pkg::ADDR_SAMPLE0;
    end else if (acc_start_in) begin
      addr_r <= acc_addr_in;
    end else if (acc_rd_in || acc_wr_in) begin
      addr_r <= next_addr(addr_r, link_ctl_r[dar_pkg::LINK_LOOP_HI:dar_pkg::LINK_LOOP_LO]);
    end
  end

  assign wr_hit = acc_wr_in && !acc_start_in;
  assign rd_hit = acc_rd_in && !acc_start_in;

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers; result bytes and unmapped bytes ignore writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skew_r     <= dar_pkg::RST_SKEW;
      gain_r     <= dar_pkg::RST_GAIN;
      link_ctl_r <= dar_pkg::RST_LINK[7:2];
      setup1_r   <= dar_pkg::RST_SETUP1;
      setup2_r   <= dar_pkg::RST_SETUP2;
    end else if (wr_hit) begin
      case (addr_r)
        dar_pkg::ADDR_SKEW:   skew_r     <= acc_wdata_in;
        dar_pkg::ADDR_GAIN:   gain_r     <= acc_wdata_in;
        dar_pkg::ADDR_LINK:   link_ctl_r <= acc_wdata_in[7:dar_pkg::LINK_CTL_LO];
        dar_pkg::ADDR_SETUP1: setup1_r   <= acc_wdata_in;
        dar_pkg::ADDR_SETUP2: setup2_r   <= acc_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Host write wins for the cycle, next modulator edge overwrites it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snapshot_r <= dar_pkg::RST_SNAPSHOT;
    end else if (wr_hit && addr_r == dar_pkg::ADDR_SNAPSHOT) begin
      snapshot_r <= acc_wdata_in;
    end else if (tick) begin
      snapshot_r <= {comp_up_s2_r, comp_lo_s2_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word period and channel skew
  assign osr_code = setup1_r[dar_pkg::SETUP1_OSR_HI:dar_pkg::SETUP1_OSR_LO];
  assign osr_mask = dar_pkg::OSR_MASK_MAX >> (2'h3 - osr_code);

  always_comb begin
    case (osr_code)
      2'h3:    skew_ext = {skew_r[7], skew_r};
      2'h2:    skew_ext = {{3{skew_r[6]}}, skew_r[5:0]};
      2'h1:    skew_ext = {{4{skew_r[5]}}, skew_r[4:0]};
      default: skew_ext = {{5{skew_r[4]}}, skew_r[3:0]};
    endcase
  end

  // Shrinking the ratio mid-period must not strand the counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_cnt_r <= 8'h00;
    end else if (tick) begin
      word_cnt_r <= (word_cnt_r >= osr_mask) ? 8'h00 : word_cnt_r + 8'h01;
    end
  end

  // Channel 1 converts at count 0; channel 0 later by the signed skew
  assign c1.conv_evt = tick && word_cnt_r == 8'h00;
  assign c0.conv_evt = tick && word_cnt_r == (skew_ext[7:0] & osr_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Channel latches
  assign c0.awake      = ~setup2_r[dar_pkg::SETUP2_RST_CH0] & ~setup2_r[dar_pkg::SETUP2_SHD_CH0];
  assign c1.awake      = ~setup2_r[dar_pkg::SETUP2_RST_CH1] & ~setup2_r[dar_pkg::SETUP2_SHD_CH1];
  assign c0.settle_en  = link_ctl_r[dar_pkg::LINK_SETTLE];
  assign c1.settle_en  = link_ctl_r[dar_pkg::LINK_SETTLE];
  assign c0.sample_raw = sample_ch0_in;
  assign c1.sample_raw = sample_ch1_in;

  assign c0.read_begin = rd_hit && addr_r <= dar_pkg::ADDR_SAMPLE0_LSB;
  assign c1.read_begin = rd_hit && addr_r >= dar_pkg::ADDR_SAMPLE1 &&
                         addr_r <= dar_pkg::ADDR_SAMPLE1_LSB;
  assign c0.read_end   = acc_end_in || (rd_hit && addr_r == dar_pkg::ADDR_SAMPLE0_LSB);
  assign c1.read_end   = acc_end_in || (rd_hit && addr_r == dar_pkg::ADDR_SAMPLE1_LSB);

  dar_chan u_chan0 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ch       (c0)
  );

  dar_chan u_chan1 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ch       (c1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ready qualification
  assign sel        = link_ctl_r[dar_pkg::LINK_SEL_HI:dar_pkg::LINK_SEL_LO];
  assign linked     = sel == dar_pkg::SEL_LINKED;
  assign done       = {c1.done, c0.done};
  assign both_ready = c0.awake && c1.awake &&
                      (pend_r[0] | done[0]) && (pend_r[1] | done[1]);

  // Pending flags collect the leading channel until the lagging one lands
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r <= 2'b00;
    end else if (!linked || !c0.awake || !c1.awake || both_ready) begin
      pend_r <= 2'b00;
    end else begin
      pend_r <= pend_r | done;
    end
  end

  always_comb begin
    case (sel)
      dar_pkg::SEL_CH0:  ready_evt = done[0];
      dar_pkg::SEL_CH1:  ready_evt = done[1];
      dar_pkg::SEL_BOTH: ready_evt = done[0] | done[1];
      default:           ready_evt = both_ready;
    endcase
  end

  // Linked select latches both results on the lagging event
  assign ev_chan    = linked ? {both_ready, both_ready} : done;
  assign c0.capture = ev_chan[0];
  assign c1.capture = ev_chan[1];

  // Status read sets, channel event clears; the event is never lost
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= dar_pkg::RST_LINK[1:0];
    end else begin
      status_r <= (status_r | {2{rd_hit && addr_r == dar_pkg::ADDR_LINK}}) & ~ev_chan;
    end
  end

  // Pulse starts on a modulator edge, ends on the next one
  always_comb begin
    if (ready_evt) begin
      ready_n_nxt = 1'b0;
    end else if (tick) begin
      ready_n_nxt = 1'b1;
    end else begin
      ready_n_nxt = sample_ready_n_out;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_ready_n_out  <= 1'b1;
      sample_ready_oe_out <= 1'b0;
    end else begin
      sample_ready_n_out  <= ready_n_nxt;
      sample_ready_oe_out <= !ready_n_nxt || link_ctl_r[dar_pkg::LINK_HIZN];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spoil_r <= 2'h0;
    end else if (wr_hit && addr_r == dar_pkg::ADDR_SNAPSHOT) begin
      spoil_r <= dar_pkg::CORRUPT_PULSES;
    end else if (ready_evt && spoil_r != 2'h0) begin
      spoil_r <= spoil_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    case (addr_r)
      dar_pkg::ADDR_SAMPLE0:     rd_mux = c0.view[23:16];
      dar_pkg::ADDR_SAMPLE0_MID: rd_mux = c0.view[15:8];
      dar_pkg::ADDR_SAMPLE0_LSB: rd_mux = c0.view[7:0];
      dar_pkg::ADDR_SAMPLE1:     rd_mux = c1.view[23:16];
      dar_pkg::ADDR_SAMPLE1_MID: rd_mux = c1.view[15:8];
      dar_pkg::ADDR_SAMPLE1_LSB: rd_mux = c1.view[7:0];
      dar_pkg::ADDR_SNAPSHOT:    rd_mux = snapshot_r;
      dar_pkg::ADDR_SKEW:        rd_mux = skew_r;
      dar_pkg::ADDR_GAIN:        rd_mux = gain_r;
      dar_pkg::ADDR_LINK:        rd_mux = {link_ctl_r, status_r};
      dar_pkg::ADDR_SETUP1:      rd_mux = setup1_r;
      dar_pkg::ADDR_SETUP2:      rd_mux = setup2_r;
      default:                   rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_rdata_out  <= 8'h00;
      acc_rvalid_out <= 1'b0;
    end else begin
      acc_rvalid_out <= rd_hit;
      if (rd_hit) begin
        acc_rdata_out <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog settings
  function automatic logic [5:0] gain_of(input logic [2:0] code);
    gain_of = (code <= dar_pkg::GAIN_CODE_MAX) ? (6'h01 << code) : 6'h01;
  endfunction : gain_of

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      amp_gain_upper_out  <= 6'h01;
      amp_gain_lower_out  <= 6'h01;
      bias_double_out     <= 2'h0;
      channel_delay_out   <= 9'sh000;
      chan_awake_out      <= 2'h0;
      results_spoiled_out <= 2'h0;
    end else begin
      amp_gain_upper_out  <= gain_of(gain_r[dar_pkg::GAIN_UPPER_HI:dar_pkg::GAIN_UPPER_LO]);
      amp_gain_lower_out  <= gain_of(gain_r[dar_pkg::GAIN_LOWER_HI:dar_pkg::GAIN_LOWER_LO]);
      bias_double_out     <= {gain_r[dar_pkg::GAIN_BIAS_CH1], gain_r[dar_pkg::GAIN_BIAS_CH0]};
      channel_delay_out   <= skew_ext;
      chan_awake_out      <= {c1.awake, c0.awake};
      results_spoiled_out <= spoil_r;
    end
  end

endmodule : dar_top

// [dar_top_asserts.sv]
`timescale 1ns/1ps
module dar_top_asserts (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // Watched ports
  input wire logic       acc_start_in,
  input wire logic       acc_rd_in,
  input wire logic [7:0] acc_rdata_out,
  input wire logic       acc_rvalid_out,
  input wire logic       sample_ready_n_out,
  input wire logic       sample_ready_oe_out,
  input wire logic [5:0] amp_gain_upper_out,
  input wire logic [5:0] amp_gain_lower_out,
  input wire logic [1:0] chan_awake_out,
  input wire logic [1:0] results_spoiled_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_read_answer_next: assert property (acc_rd_in && !acc_start_in |=> acc_rvalid_out)
    else $error("read not answered");
  chk_answer_cause: assert property (acc_rvalid_out |-> $past(acc_rd_in && !acc_start_in))
    else $error("answer without read");
  chk_rdata_holds: assert property (!acc_rvalid_out |-> $stable(acc_rdata_out))
    else $error("read data moved");
  chk_low_is_driven: assert property (!sample_ready_n_out |-> sample_ready_oe_out)
    else $error("ready low not driven");
  chk_pulse_one_period: assert property ($fell(sample_ready_n_out) |->
    (!sample_ready_n_out)[*6] ##[1:3] sample_ready_n_out)
    else $error("ready pulse width wrong");
  chk_gain_legal: assert property ($onehot(amp_gain_upper_out) &&
    $onehot(amp_gain_lower_out) && amp_gain_upper_out <= 6'h20 && amp_gain_lower_out <= 6'h20)
    else $error("gain outside set");
  chk_sleep_quiet: assert property (chan_awake_out == 2'b00 &&
    $past(chan_awake_out) == 2'b00 |-> !$fell(sample_ready_n_out))
    else $error("pulse while asleep");
  chk_spoil_step: assert property ($changed(results_spoiled_out) &&
    results_spoiled_out != 2'h3 |-> results_spoiled_out == $past(results_spoiled_out) - 2'h1)
    else $error("spoil count jumped");
endmodule : dar_top_asserts

bind dar_top dar_top_asserts u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .acc_start_in(acc_start_in), .acc_rd_in(acc_rd_in),
  .acc_rdata_out(acc_rdata_out), .acc_rvalid_out(acc_rvalid_out),
  .sample_ready_n_out(sample_ready_n_out), .sample_ready_oe_out(sample_ready_oe_out),
  .amp_gain_upper_out(amp_gain_upper_out), .amp_gain_lower_out(amp_gain_lower_out),
  .chan_awake_out(chan_awake_out), .results_spoiled_out(results_spoiled_out));

// [dar_analog_model.sv]
`timescale 1ns/1ps
module dar_analog_model (
  // Control
  input  wire logic   run_in,
  // Converter side
  output logic        mod_clk_out,
  output logic [3:0]  comp_upper_out,
  output logic [3:0]  comp_lower_out,
  output logic [23:0] sample_ch0_out,
  output logic [23:0] sample_ch1_out
);
  // Held words, so captures never race a change
  assign comp_upper_out = 4'h9;
  assign comp_lower_out = 4'h6;
  assign sample_ch0_out = 24'hA1B2C3;
  assign sample_ch1_out = 24'h5D6E7F;
  // Odd phase against the system clock
  initial begin
    mod_clk_out = 1'b0;
    #7;
    forever begin
      #100;
      mod_clk_out = run_in ? ~mod_clk_out : 1'b0;
    end
  end
endmodule : dar_analog_model

// [dar_top_tb_top.sv]
`timescale 1ns/1ps
module dar_top_tb_top;
  logic clk_in, rst_n_in, run, mod_clk_in, acc_start_in, acc_rd_in, acc_wr_in, acc_end_in;
  logic [3:0] comp_upper_in, comp_lower_in, acc_addr_in;
  logic [23:0] sample_ch0_in, sample_ch1_in;
  logic [7:0] acc_wdata_in, acc_rdata_out, b;
  logic acc_rvalid_out, sample_ready_n_out, sample_ready_oe_out;
  logic [5:0] amp_gain_upper_out, amp_gain_lower_out;
  logic [1:0] bias_double_out, chan_awake_out, results_spoiled_out;
  logic signed [8:0] channel_delay_out;
  logic [47:0] words = 48'hA1B2C35D6E7F;
  logic [7:0] rst_tab [6] = '{8'h33, 8'h00, 8'h00, 8'hA3, 8'h10, 8'h0C};
  int err_count, num_checks, cyc, n;
  ////////////////////////////////////////
  dar_analog_model u_model (.run_in(run), .mod_clk_out(mod_clk_in),
    .comp_upper_out(comp_upper_in), .comp_lower_out(comp_lower_in),
    .sample_ch0_out(sample_ch0_in), .sample_ch1_out(sample_ch1_in));
  dar_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .mod_clk_in(mod_clk_in),
    .comp_upper_in(comp_upper_in), .comp_lower_in(comp_lower_in),
    .sample_ch0_in(sample_ch0_in), .sample_ch1_in(sample_ch1_in),
    .acc_start_in(acc_start_in), .acc_addr_in(acc_addr_in), .acc_rd_in(acc_rd_in),
    .acc_wr_in(acc_wr_in), .acc_wdata_in(acc_wdata_in), .acc_end_in(acc_end_in),
    .acc_rdata_out(acc_rdata_out), .acc_rvalid_out(acc_rvalid_out),
    .sample_ready_n_out(sample_ready_n_out), .sample_ready_oe_out(sample_ready_oe_out),
    .amp_gain_upper_out(amp_gain_upper_out), .amp_gain_lower_out(amp_gain_lower_out),
    .bias_double_out(bias_double_out), .channel_delay_out(channel_delay_out),
    .chan_awake_out(chan_awake_out), .results_spoiled_out(results_spoiled_out));
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic sel(input logic [3:0] a);
    @(negedge clk_in);
    acc_start_in = 1'b1;
    acc_addr_in = a;
    @(negedge clk_in);
    acc_start_in = 1'b0;
  endtask : sel
  task automatic fin();
    @(negedge clk_in);
    acc_end_in = 1'b1;
    @(negedge clk_in);
    acc_end_in = 1'b0;
  endtask : fin
  // Read data is taken once the answer has landed
  task automatic rd(output logic [7:0] d);
    @(negedge clk_in);
    acc_rd_in = 1'b1;
    @(negedge clk_in);
    acc_rd_in = 1'b0;
    @(posedge clk_in);
    #1;
    d = acc_rdata_out;
  endtask : rd
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    sel(a);
    @(negedge clk_in);
    acc_wr_in = 1'b1;
    acc_wdata_in = d;
    @(negedge clk_in);
    acc_wr_in = 1'b0;
    fin();
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    sel(a);
    rd(b);
    chk(24'(b), 24'(exp));
    fin();
  endtask : rreg
  // Falling edges over four word periods at ratio 32
  task automatic cnt(output int c);
    logic prev;
    c = 0;
    prev = sample_ready_n_out;
    repeat (1024) begin
      @(posedge clk_in);
      #1;
      if (prev === 1'b1 && sample_ready_n_out === 1'b0) c++;
      prev = sample_ready_n_out;
    end
  endtask : cnt
  ////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    {rst_n_in, run, acc_start_in, acc_rd_in, acc_wr_in, acc_end_in} = '0;
    acc_addr_in = 4'h0;
    acc_wdata_in = 8'h00;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++) rreg(4'h6 + 4'(i), rst_tab[i]);
    rreg(4'hC, 8'h00);
    run = 1'b1;
    repeat (40) @(negedge clk_in);
    rreg(4'h6, 8'h96);
    for (int c = 0; c < 8; c++) begin
      wreg(4'h8, {3'(c), 2'b10, 3'(c)});
      chk(24'(amp_gain_upper_out), (c < 6) ? (24'h1 << c) : 24'h1);
      chk(24'(amp_gain_lower_out), (c < 6) ? (24'h1 << c) : 24'h1);
      chk(24'(bias_double_out), 24'h2);
    end
    wreg(4'hA, 8'h00);
    wreg(4'h7, 8'h18);
    chk({15'h0, channel_delay_out}, 24'h1F8);
    wreg(4'hA, 8'h30);
    chk({15'h0, channel_delay_out}, 24'h018);
    wreg(4'hA, 8'h00);
    wreg(4'h7, 8'h00);
    wreg(4'h0, 8'hFF);
    wreg(4'h9, 8'hA0);
    repeat (1100) @(negedge clk_in);
    cnt(n);
    chk(24'(n), 24'h4);
    sel(4'h0);
    for (int i = 0; i < 6; i++) begin
      rd(b);
      chk(24'(b), 24'(words[47-8*i -: 8]));
    end
    fin();
    // Linked with one channel asleep, so no pulse eats the spoil count
    wreg(4'hB, 8'h1C);
    wreg(4'h6, 8'h00);
    chk(24'(results_spoiled_out), 24'h3);
    cnt(n);
    chk(24'(n), 24'h0);
    chk(24'(results_spoiled_out), 24'h3);
    chk(24'(sample_ready_oe_out), 24'h0);
    wreg(4'h9, 8'hBC);
    cnt(n);
    chk(24'(n), 24'h4);
    chk(24'(results_spoiled_out), 24'h0);
    chk(24'(sample_ready_oe_out), 24'h1);
    wreg(4'h9, 8'hA8);
    cnt(n);
    chk(24'(n), 24'h4);
    wreg(4'h9, 8'hA4);
    cnt(n);
    chk(24'(n), 24'h0);
    wreg(4'hB, 8'h3C);
    wreg(4'h9, 8'hAC);
    cnt(n);
    chk(24'(n), 24'h0);
    wreg(4'h9, 8'h40);
    sel(4'h8);
    rd(b);
    chk(24'(b), 24'hF7);
    rd(b);
    chk(24'(b), 24'h96);
    fin();
    wreg(4'h9, 8'hC0);
    sel(4'hB);
    rd(b);
    chk(24'(b), 24'h3C);
    rd(b);
    chk(24'(b), 24'hA1);
    fin();
    wreg(4'h9, 8'h00);
    sel(4'h8);
    rd(b);
    rd(b);
    chk(24'(b), 24'hF7);
    fin();
    // Skew set while asleep, so the first lagging event is a whole pair
    wreg(4'h7, 8'h08);
    wreg(4'hB, 8'h0C);
    repeat (300) @(negedge clk_in);
    cnt(n);
    chk(24'(n), 24'h4);
    wreg(4'h9, 8'h0C);
    cnt(n);
    chk(24'(n), 24'h8);
    end_of_test();
  end
endmodule : dar_top_tb_top
